// ===== inc/pefm_map.vh
`ifndef PEFM_MAP_VH
`define PEFM_MAP_VH

// Port E pin positions
`define PEFM_E_RX 0
`define PEFM_E_TX 1
`define PEFM_E_XCK 2
`define PEFM_E_CMPA 3
`define PEFM_E_CMPB 4
`define PEFM_E_CMPC 5
`define PEFM_E_CNT 6
`define PEFM_E_CAP 7
`define PEFM_E_IRQ_LO 4
`define PEFM_E_IRQ_HI 7

// Port F test pin positions
`define PEFM_F_TCK 4
`define PEFM_F_TMS 5
`define PEFM_F_TDO 6
`define PEFM_F_TDI 7

// Constant override patterns
`define PEFM_ZERO8 8'h00
`define PEFM_ONES8 8'hFF
`define PEFM_E_PIN_MASK 8'h03
`define PEFM_E_DIR_VAL 8'h02
`define PEFM_F_TEST_MASK 8'hF0
`define PEFM_F_TEST_PU 8'hB0
`define PEFM_F_TDO_MASK 8'h40

// Test port instruction and data registers
`define PEFM_IR_W 4
`define PEFM_IR_BYPASS 4'hF
`define PEFM_IR_CAPTURE 4'h1
`define PEFM_DR_W 8
`define PEFM_DR_RESET 8'h00

`endif

// ===== core/pefm_top.v
// Behaviour
// - Receiver enable forces E0 to input regardless of direction bit.
// - Forced E0 input gets pull-up from its output bit unless globally disabled.
// - Transmitter enable makes E1 an output carrying transmit data, pull-up off.
// - E2 clock pin direction from its bit; sync mode overrides output value.
// - Timer3 compare C drives E5 when enabled; software sets direction.
// - Timer3 compare B drives E4 when enabled; software sets direction.
// - Timer3 compare A drives E3 when enabled; software sets direction.
// - E4..E7 feed external interrupts; enabled interrupt forces input enable on.
// - E7 input routed to timer3 capture, no direction or pull-up override.
// - E6 input routed to timer3 count clock, no direction or pull-up override.
// - E2 and E3 reach the comparator as analogue, no analogue or input enable override.
// - Serial programming uses E1 as data out and E0 as data in.
// - Legacy mode makes all Port F pins input only, except TDO in shift states while the test port is enabled.
// - Test port enabled keeps TDI, TMS, TCK pull-ups on, even in reset.
// - Test port enabled takes test pins away from port registers.
// - TDI shifts into instruction or selected data register by state.
// - TDO floats except in shift instruction or shift data states.
// - Legacy mode disables timer3 and serial clock functions on Port E.
// - Global pull-up disable turns off port pull-ups, except TDI, TMS and TCK while the test port is enabled.
// - Test port activity advances on edges of the test clock pin.
`timescale 1ns/1ps
`default_nettype none
`include "pefm_map.vh"

module pefm_top (
	input wire I_REF_CLK,
	input wire I_RST,
	input wire [7:0] I_PORT_E_OUTPUT,
	input wire [7:0] I_PORT_E_DIRECTION,
	input wire [7:0] I_PORT_F_OUTPUT,
	input wire [7:0] I_PORT_F_DIRECTION,
	input wire I_GLOBAL_PULLUP_DISABLE,
	input wire I_LEGACY_MODE,
	input wire I_INPUT_SLEEP_GATE,
	input wire I_SERIAL0_RX_ENABLE,
	input wire I_SERIAL0_TX_ENABLE,
	input wire I_SERIAL0_TX_DATA,
	input wire I_SERIAL0_SYNC_SELECT,
	input wire I_SERIAL0_CLOCK_OUT,
	input wire I_TIMER3_COMPARE_A_EN,
	input wire I_TIMER3_COMPARE_A_OUT,
	input wire I_TIMER3_COMPARE_B_EN,
	input wire I_TIMER3_COMPARE_B_OUT,
	input wire I_TIMER3_COMPARE_C_EN,
	input wire I_TIMER3_COMPARE_C_OUT,
	input wire [3:0] I_EXT_IRQ_ENABLE,
	input wire I_PROG_MODE,
	input wire I_PROG_SERIAL_OUT,
	input wire I_TEST_PORT_ENABLE,
	input wire [7:0] I_PE_PIN,
	input wire [7:0] I_PF_PIN,
	output wire [7:0] O_PE_PULLUP,
	output wire [7:0] O_PE_OE,
	output wire [7:0] O_PE_OUT,
	output wire [7:0] O_PE_IN_EN,
	output wire [7:0] O_PF_PULLUP,
	output wire [7:0] O_PF_OE,
	output wire [7:0] O_PF_OUT,
	output wire [7:0] O_PF_IN_EN,
	output wire [7:0] O_PE_IN_SYNC,
	output wire [7:0] O_PF_IN_SYNC,
	output wire O_SERIAL0_RX_PIN,
	output wire O_SERIAL0_CLOCK_PIN,
	output wire O_TIMER3_CAPTURE_IN,
	output wire O_TIMER3_COUNT_CLOCK_IN,
	output wire [3:0] O_EXT_IRQ_IN,
	output wire O_PROG_SERIAL_IN,
	output wire [3:0] O_TAP_STATE,
	output wire [3:0] O_TAP_IR
);

	localparam [3:0] ST_RESET = 4'h0;
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_SEL_DR = 4'h2;
	localparam [3:0] ST_CAP_DR = 4'h3;
	localparam [3:0] ST_SHIFT_DR = 4'h4;
	localparam [3:0] ST_EXIT1_DR = 4'h5;
	localparam [3:0] ST_PAUSE_DR = 4'h6;
	localparam [3:0] ST_EXIT2_DR = 4'h7;
	localparam [3:0] ST_UPD_DR = 4'h8;
	localparam [3:0] ST_SEL_IR = 4'h9;
	localparam [3:0] ST_CAP_IR = 4'hA;
	localparam [3:0] ST_SHIFT_IR = 4'hB;
	localparam [3:0] ST_EXIT1_IR = 4'hC;
	localparam [3:0] ST_PAUSE_IR = 4'hD;
	localparam [3:0] ST_EXIT2_IR = 4'hE;
	localparam [3:0] ST_UPD_IR = 4'hF;

	// Override merge: enabled bits take the override value
	function [7:0] ovr;
		input [7:0] en;
		input [7:0] val;
		input [7:0] base;
		begin
			ovr = (base & ~en) | (val & en);
		end
	endfunction

	// Accept a new level once stages two and three agree
	function [7:0] agree;
		input [7:0] s2;
		input [7:0] s3;
		input [7:0] held;
		begin
			agree = ovr(~(s2 ^ s3), s2, held);
		end
	endfunction

	// Test state machine step
	function [3:0] tap_next;
		input [3:0] st;
		input tms;
		begin
			case (st)
			ST_RESET: tap_next = tms ? ST_RESET : ST_IDLE;
			ST_IDLE: tap_next = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: tap_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: tap_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: tap_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: tap_next = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: tap_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: tap_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: tap_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
			default: tap_next = ST_RESET;
			endcase
		end
	endfunction

	reg [7:0] pe_s1_q, pe_s2_q, pe_s3_q, pe_filt_q;
	reg [7:0] pf_s1_q, pf_s2_q, pf_s3_q, pf_filt_q;
	reg tck_prev_q;
	reg [3:0] tap_q, tap_d;
	reg [`PEFM_IR_W-1:0] ir_q, ir_sh_q;
	reg [`PEFM_DR_W-1:0] dr_q, dr_sh_q;
	reg byp_q;
	reg tdo_q;
	reg [7:0] pe_pu_q, pe_oe_q, pe_out_q, pe_ien_q;
	reg [7:0] pf_pu_q, pf_oe_q, pf_out_q, pf_ien_q;
	reg [7:0] pe_pu_d, pe_oe_d, pe_out_d, pe_ien_d;
	reg [7:0] pf_pu_d, pf_oe_d, pf_out_d, pf_ien_d;
	reg [7:0] pe_pullup_override_enable, pe_pullup_override_value, pe_direction_override_enable, pe_port_value_override_enable, pe_port_value_override_value, pe_ieoe;
	reg [7:0] pf_base_oe;

	wire global_pullup_disable = I_GLOBAL_PULLUP_DISABLE;
	wire leg = I_LEGACY_MODE;
	wire jtag = I_TEST_PORT_ENABLE;
	wire rx_force = I_SERIAL0_RX_ENABLE | I_PROG_MODE;
	wire tx_force = I_SERIAL0_TX_ENABLE | I_PROG_MODE;
	wire tck = pf_filt_q[`PEFM_F_TCK];
	wire tms = pf_filt_q[`PEFM_F_TMS];
	wire tdi = pf_filt_q[`PEFM_F_TDI];
	wire tck_rise = tck & ~tck_prev_q;
	wire tck_fall = ~tck & tck_prev_q;
	wire sel_byp = (ir_q == `PEFM_IR_BYPASS);
	wire shifting = (tap_q == ST_SHIFT_IR) | (tap_q == ST_SHIFT_DR);

	// Pin input synchronisers
	always @(posedge I_REF_CLK) begin
		if (I_RST) begin
			pe_s1_q <= `PEFM_ZERO8;
			pe_s2_q <= `PEFM_ZERO8;
			pe_s3_q <= `PEFM_ZERO8;
			pe_filt_q <= `PEFM_ZERO8;
			pf_s1_q <= `PEFM_ZERO8;
			pf_s2_q <= `PEFM_ZERO8;
			pf_s3_q <= `PEFM_ZERO8;
			pf_filt_q <= `PEFM_ZERO8;
			tck_prev_q <= 1'b0;
		end else begin
			pe_s1_q <= I_PE_PIN;
			pe_s2_q <= pe_s1_q;
			pe_s3_q <= pe_s2_q;
			pe_filt_q <= agree(pe_s2_q, pe_s3_q, pe_filt_q);
			pf_s1_q <= I_PF_PIN;
			pf_s2_q <= pf_s1_q;
			pf_s3_q <= pf_s2_q;
			pf_filt_q <= agree(pf_s2_q, pf_s3_q, pf_filt_q);
			tck_prev_q <= tck;
		end
	end

	// Test state machine, stepped by rising test clock edges
	always @* begin
		tap_d = tap_q;
		if (!jtag)
			tap_d = ST_RESET;
		else if (tck_rise)
			tap_d = tap_next(tap_q, tms);
	end

	always @(posedge I_REF_CLK) begin
		if (I_RST) begin
			tap_q <= ST_RESET;
			ir_q <= `PEFM_IR_BYPASS;
			ir_sh_q <= `PEFM_IR_BYPASS;
			dr_q <= `PEFM_DR_RESET;
			dr_sh_q <= `PEFM_DR_RESET;
			byp_q <= 1'b0;
			tdo_q <= 1'b0;
		end else begin
			tap_q <= tap_d;
			if (tap_q == ST_RESET)
				ir_q <= `PEFM_IR_BYPASS;
			if (jtag && tck_rise) begin
				case (tap_q)
				ST_CAP_IR: ir_sh_q <= `PEFM_IR_CAPTURE;
				ST_SHIFT_IR: ir_sh_q <= {tdi, ir_sh_q[`PEFM_IR_W-1:1]};
				ST_UPD_IR: ir_q <= ir_sh_q;
				ST_CAP_DR: begin
					byp_q <= 1'b0;
					dr_sh_q <= dr_q;
				end
				ST_SHIFT_DR: begin
					if (sel_byp)
						byp_q <= tdi;
					else
						dr_sh_q <= {tdi, dr_sh_q[`PEFM_DR_W-1:1]};
				end
				ST_UPD_DR: begin
					if (!sel_byp)
						dr_q <= dr_sh_q;
				end
				default: begin
				end
				endcase
			end
			if (jtag && tck_fall) begin
				if (tap_q == ST_SHIFT_IR)
					tdo_q <= ir_sh_q[0];
				else
					tdo_q <= sel_byp ? byp_q : dr_sh_q[0];
			end
		end
	end

	// Port E override terms
	always @* begin
		pe_pullup_override_enable = `PEFM_ZERO8;
		pe_pullup_override_value = `PEFM_ZERO8;
		pe_direction_override_enable = `PEFM_ZERO8;
		pe_port_value_override_enable = `PEFM_ZERO8;
		pe_port_value_override_value = `PEFM_ZERO8;
		pe_ieoe = `PEFM_ZERO8;
		pe_direction_override_enable[`PEFM_E_RX] = rx_force;
		pe_pullup_override_enable[`PEFM_E_RX] = rx_force;
		pe_pullup_override_value[`PEFM_E_RX] = I_PORT_E_OUTPUT[`PEFM_E_RX] & ~global_pullup_disable;
		pe_pullup_override_enable[`PEFM_E_TX] = tx_force;
		pe_direction_override_enable[`PEFM_E_TX] = tx_force;
		pe_port_value_override_enable[`PEFM_E_TX] = tx_force;
		pe_port_value_override_value[`PEFM_E_TX] = I_PROG_MODE ? I_PROG_SERIAL_OUT :
			I_SERIAL0_TX_DATA;
		pe_port_value_override_enable[`PEFM_E_XCK] = I_SERIAL0_SYNC_SELECT & ~leg;
		pe_port_value_override_value[`PEFM_E_XCK] = I_SERIAL0_CLOCK_OUT;
		pe_port_value_override_enable[`PEFM_E_CMPA] = I_TIMER3_COMPARE_A_EN & ~leg;
		pe_port_value_override_value[`PEFM_E_CMPA] = I_TIMER3_COMPARE_A_OUT;
		pe_port_value_override_enable[`PEFM_E_CMPB] = I_TIMER3_COMPARE_B_EN & ~leg;
		pe_port_value_override_value[`PEFM_E_CMPB] = I_TIMER3_COMPARE_B_OUT;
		pe_port_value_override_enable[`PEFM_E_CMPC] = I_TIMER3_COMPARE_C_EN & ~leg;
		pe_port_value_override_value[`PEFM_E_CMPC] = I_TIMER3_COMPARE_C_OUT;
		pe_ieoe[`PEFM_E_IRQ_HI:`PEFM_E_IRQ_LO] = I_EXT_IRQ_ENABLE;
	end

	// Pin resolution; comparator pins E2, E3 carry no analogue override
	always @* begin
		pe_pu_d = ovr(pe_pullup_override_enable, pe_pullup_override_value,
			I_PORT_E_OUTPUT & ~I_PORT_E_DIRECTION & {8{~global_pullup_disable}});
		pe_oe_d = ovr(pe_direction_override_enable, `PEFM_E_DIR_VAL & `PEFM_E_PIN_MASK,
			I_PORT_E_DIRECTION);
		pe_out_d = ovr(pe_port_value_override_enable, pe_port_value_override_value, I_PORT_E_OUTPUT);
		pe_ien_d = ovr(pe_ieoe, `PEFM_ONES8,
			{8{~I_INPUT_SLEEP_GATE}});
		pf_base_oe = leg ? `PEFM_ZERO8 : I_PORT_F_DIRECTION;
		pf_pu_d = ovr({8{jtag}} & `PEFM_F_TEST_MASK, `PEFM_F_TEST_PU,
			I_PORT_F_OUTPUT & ~pf_base_oe & {8{~global_pullup_disable}});
		pf_oe_d = ovr({8{jtag}} & `PEFM_F_TEST_MASK,
			{8{shifting}} & `PEFM_F_TDO_MASK, pf_base_oe);
		pf_out_d = ovr({8{jtag}} & `PEFM_F_TDO_MASK, {8{tdo_q}},
			leg ? `PEFM_ZERO8 : I_PORT_F_OUTPUT);
		pf_ien_d = ovr({8{jtag}} & `PEFM_F_TEST_MASK, `PEFM_ZERO8,
			{8{~I_INPUT_SLEEP_GATE}});
	end

	// Registered pin controls; test pin pull-ups survive reset
	always @(posedge I_REF_CLK) begin
		if (I_RST) begin
			pe_pu_q <= `PEFM_ZERO8;
			pe_oe_q <= `PEFM_ZERO8;
			pe_out_q <= `PEFM_ZERO8;
			pe_ien_q <= `PEFM_ONES8;
			pf_pu_q <= {8{jtag}} & `PEFM_F_TEST_PU;
			pf_oe_q <= `PEFM_ZERO8;
			pf_out_q <= `PEFM_ZERO8;
			pf_ien_q <= `PEFM_ONES8;
		end else begin
			pe_pu_q <= pe_pu_d;
			pe_oe_q <= pe_oe_d;
			pe_out_q <= pe_out_d;
			pe_ien_q <= pe_ien_d;
			pf_pu_q <= pf_pu_d;
			pf_oe_q <= pf_oe_d;
			pf_out_q <= pf_out_d;
			pf_ien_q <= pf_ien_d;
		end
	end

	assign O_PE_PULLUP = pe_pu_q;
	assign O_PE_OE = pe_oe_q;
	assign O_PE_OUT = pe_out_q;
	assign O_PE_IN_EN = pe_ien_q;
	assign O_PF_PULLUP = pf_pu_q;
	assign O_PF_OE = pf_oe_q;
	assign O_PF_OUT = pf_out_q;
	assign O_PF_IN_EN = pf_ien_q;
	assign O_PE_IN_SYNC = pe_filt_q & pe_ien_q;
	assign O_PF_IN_SYNC = pf_filt_q & pf_ien_q;

	// Peripheral input routing
	assign O_SERIAL0_RX_PIN = pe_filt_q[`PEFM_E_RX];
	assign O_PROG_SERIAL_IN = pe_filt_q[`PEFM_E_RX];
	assign O_SERIAL0_CLOCK_PIN = pe_filt_q[`PEFM_E_XCK] &
		I_SERIAL0_SYNC_SELECT & ~leg;
	assign O_TIMER3_CAPTURE_IN = pe_filt_q[`PEFM_E_CAP] & ~leg;
	assign O_TIMER3_COUNT_CLOCK_IN = pe_filt_q[`PEFM_E_CNT] &
		~leg;
	assign O_EXT_IRQ_IN = pe_filt_q[`PEFM_E_IRQ_HI:`PEFM_E_IRQ_LO];
	assign O_TAP_STATE = tap_q;
	assign O_TAP_IR = ir_q;

endmodule // pefm_top
`default_nettype wire

// ===== tb/pefm_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pefm_chk (
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	input wire logic [7:0] I_PORT_E_OUTPUT,
	input wire logic [7:0] I_PORT_E_DIRECTION,
	input wire logic I_GLOBAL_PULLUP_DISABLE,
	input wire logic I_LEGACY_MODE,
	input wire logic I_INPUT_SLEEP_GATE,
	input wire logic I_SERIAL0_RX_ENABLE,
	input wire logic I_SERIAL0_TX_ENABLE,
	input wire logic I_SERIAL0_TX_DATA,
	input wire logic I_SERIAL0_SYNC_SELECT,
	input wire logic I_SERIAL0_CLOCK_OUT,
	input wire logic I_TIMER3_COMPARE_A_EN,
	input wire logic I_TIMER3_COMPARE_A_OUT,
	input wire logic [3:0] I_EXT_IRQ_ENABLE,
	input wire logic I_PROG_MODE,
	input wire logic I_TEST_PORT_ENABLE,
	input wire logic [7:0] O_PE_PULLUP,
	input wire logic [7:0] O_PE_OE,
	input wire logic [7:0] O_PE_OUT,
	input wire logic [7:0] O_PE_IN_EN,
	input wire logic [7:0] O_PF_OE,
	input wire logic [3:0] O_TAP_STATE
);
	logic r_q = 1'b1;
	always_ff @(posedge I_REF_CLK) r_q <= I_RST;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_RST);
	property p_rx;
		!r_q && $past(I_SERIAL0_RX_ENABLE) |-> !O_PE_OE[0];
	endproperty
	a_rx: assert property (p_rx) else $error("rx pin driven");
	property p_tx;
		!r_q && $past(I_SERIAL0_TX_ENABLE && !I_PROG_MODE) |-> O_PE_OE[1]
			&& !O_PE_PULLUP[1] && O_PE_OUT[1] == $past(I_SERIAL0_TX_DATA);
	endproperty
	a_tx: assert property (p_tx) else $error("tx pin wrong");
	property p_xck;
		!r_q && $past(I_SERIAL0_SYNC_SELECT && !I_LEGACY_MODE)
			|-> O_PE_OUT[2] == $past(I_SERIAL0_CLOCK_OUT);
	endproperty
	a_xck: assert property (p_xck) else $error("clock pin wrong");
	property p_cmpa;
		!r_q && $past(I_TIMER3_COMPARE_A_EN && !I_LEGACY_MODE)
			|-> O_PE_OUT[3] == $past(I_TIMER3_COMPARE_A_OUT)
			&& O_PE_OE[3] == $past(I_PORT_E_DIRECTION[3]);
	endproperty
	a_cmpa: assert property (p_cmpa) else $error("compare a wrong");
	property p_irq;
		!r_q |-> O_PE_IN_EN[7:4]
			== $past(I_EXT_IRQ_ENABLE | {4{!I_INPUT_SLEEP_GATE}});
	endproperty
	a_irq: assert property (p_irq) else $error("irq input off");
	property p_pfin;
		!r_q && $past(I_LEGACY_MODE && !I_TEST_PORT_ENABLE)
			|-> O_PF_OE == 8'h00;
	endproperty
	a_pfin: assert property (p_pfin) else $error("port f driven");
	property p_tdo;
		!r_q && $past(I_TEST_PORT_ENABLE) |-> O_PF_OE[6]
			== $past(O_TAP_STATE == 4'h4 || O_TAP_STATE == 4'hB);
	endproperty
	a_tdo: assert property (p_tdo) else $error("tdo drive wrong");
	property p_pud;
		!r_q && $past(I_GLOBAL_PULLUP_DISABLE) |-> O_PE_PULLUP == 8'h00;
	endproperty
	a_pud: assert property (p_pud) else $error("pull-up on");
	property p_dflt;
		!r_q && $past(!I_SERIAL0_RX_ENABLE && !I_SERIAL0_TX_ENABLE
			&& !I_PROG_MODE) |-> O_PE_OE == $past(I_PORT_E_DIRECTION);
	endproperty
	a_dflt: assert property (p_dflt) else $error("direction wrong");
endmodule // pefm_chk
bind pefm_top pefm_chk pefm_chk_i (.*);
`default_nettype wire

// ===== tb/pefm_board.sv
`timescale 1ns/1ps
`default_nettype none
module pefm_board (
	input wire logic i_clk,
	input wire logic [15:0] i_oe,
	input wire logic [15:0] i_out,
	input wire logic [15:0] i_pu,
	input wire logic [15:0] i_drv,
	input wire logic [15:0] i_den,
	output logic [15:0] o_pad
);
	logic flt_q = 1'b0;
	always @(posedge i_clk) flt_q <= !flt_q;
	// Device first, then board, then pull-up; bare pins wander
	assign o_pad = (i_oe & i_out) | (~i_oe & i_den & i_drv)
		| (~i_oe & ~i_den & (i_pu | {16{flt_q}}));
endmodule // pefm_board
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic I_REF_CLK = 0, I_RST = 1;
	logic [7:0] I_PORT_E_OUTPUT = 0, I_PORT_E_DIRECTION = 0;
	logic [7:0] I_PORT_F_OUTPUT = 0, I_PORT_F_DIRECTION = 0;
	logic I_GLOBAL_PULLUP_DISABLE = 0, I_LEGACY_MODE = 0;
	logic I_INPUT_SLEEP_GATE = 0, I_SERIAL0_RX_ENABLE = 0;
	logic I_SERIAL0_TX_ENABLE = 0, I_SERIAL0_TX_DATA = 0;
	logic I_SERIAL0_SYNC_SELECT = 0, I_SERIAL0_CLOCK_OUT = 0;
	logic I_TIMER3_COMPARE_A_EN = 0, I_TIMER3_COMPARE_A_OUT = 0;
	logic I_TIMER3_COMPARE_B_EN = 0, I_TIMER3_COMPARE_B_OUT = 0;
	logic I_TIMER3_COMPARE_C_EN = 0, I_TIMER3_COMPARE_C_OUT = 0;
	logic [3:0] I_EXT_IRQ_ENABLE = 0;
	logic I_PROG_MODE = 0, I_PROG_SERIAL_OUT = 0, I_TEST_PORT_ENABLE = 1;
	wire [7:0] I_PE_PIN, I_PF_PIN, O_PE_PULLUP, O_PE_OE, O_PE_OUT;
	wire [7:0] O_PE_IN_EN, O_PF_PULLUP, O_PF_OE, O_PF_OUT, O_PF_IN_EN;
	wire [7:0] O_PE_IN_SYNC, O_PF_IN_SYNC;
	wire O_SERIAL0_RX_PIN, O_SERIAL0_CLOCK_PIN, O_TIMER3_CAPTURE_IN;
	wire O_TIMER3_COUNT_CLOCK_IN, O_PROG_SERIAL_IN;
	wire [3:0] O_EXT_IRQ_IN, O_TAP_STATE, O_TAP_IR;
	logic [7:0] e_drv = 0, e_den = 0, f_drv = 0, f_den = 8'hB0;
	logic [15:0] tms_seq = 16'h60DF, tdi_seq = 16'h0C00;
	int err_count = 0, n_tests = 0;
	pefm_top pefm_top_i (.*);
	pefm_board pefm_board_i (.i_clk(I_REF_CLK), .i_oe({O_PF_OE, O_PE_OE}),
		.i_out({O_PF_OUT, O_PE_OUT}), .i_pu({O_PF_PULLUP, O_PE_PULLUP}),
		.i_drv({f_drv, e_drv}), .i_den({f_den, e_den}),
		.o_pad({I_PF_PIN, I_PE_PIN}));
	initial forever #4 I_REF_CLK = ~I_REF_CLK;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge I_REF_CLK);
		#1;
	endtask
	// One test clock period, TCK low then high
	task automatic tck(input logic tms, input logic tdi);
		@(posedge I_REF_CLK);
		f_drv <= {tdi, 1'b0, tms, 5'h00};
		repeat (8) @(posedge I_REF_CLK);
		f_drv[4] <= 1'b1;
		step(8);
	endtask
	task automatic final_report;
		if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		step(5);
		chk(O_PE_OE, 8'h00);
		chk(O_PE_IN_EN, 8'hFF);
		chk(O_PF_PULLUP, 8'hB0);
		chk({O_TAP_STATE, O_TAP_IR}, 8'h0F);
		@(posedge I_REF_CLK);
		I_RST <= 0;
		I_TEST_PORT_ENABLE <= 0;
		I_PORT_E_DIRECTION <= 8'h25;
		I_PORT_E_OUTPUT <= 8'h3C;
		step(2);
		chk(O_PE_OE, 8'h25);
		chk(O_PE_OUT, 8'h3C);
		chk(O_PE_PULLUP, 8'h18);
		@(posedge I_REF_CLK);
		I_GLOBAL_PULLUP_DISABLE <= 1;
		step(1);
		chk(O_PE_PULLUP, 8'h00);
		@(posedge I_REF_CLK);
		I_GLOBAL_PULLUP_DISABLE <= 0;
		I_PORT_E_OUTPUT <= 8'h3D;
		I_SERIAL0_RX_ENABLE <= 1;
		e_den <= 8'hC1;
		e_drv <= 8'h81;
		step(1);
		chk(O_PE_OE, 8'h24);
		chk(O_PE_PULLUP, 8'h19);
		step(7);
		chk({O_SERIAL0_RX_PIN, O_PROG_SERIAL_IN, O_TIMER3_CAPTURE_IN,
			O_TIMER3_COUNT_CLOCK_IN}, 8'h0E);
		@(posedge I_REF_CLK);
		I_LEGACY_MODE <= 1;
		I_INPUT_SLEEP_GATE <= 1;
		I_EXT_IRQ_ENABLE <= 4'h5;
		I_SERIAL0_TX_ENABLE <= 1;
		I_SERIAL0_TX_DATA <= 1;
		step(2);
		chk({O_TIMER3_CAPTURE_IN, O_TIMER3_COUNT_CLOCK_IN}, 8'h00);
		chk(O_PE_IN_EN, 8'h50);
		chk({O_PE_OE[1], O_PE_OUT[1], O_PE_PULLUP[1]}, 8'h06);
		@(posedge I_REF_CLK);
		I_PROG_MODE <= 1;
		I_PORT_E_DIRECTION <= 8'h3C;
		I_PORT_E_OUTPUT <= 8'h00;
		I_PORT_F_DIRECTION <= 8'hFF;
		I_PORT_F_OUTPUT <= 8'hFF;
		{I_SERIAL0_SYNC_SELECT, I_SERIAL0_CLOCK_OUT} <= 2'b11;
		{I_TIMER3_COMPARE_A_EN, I_TIMER3_COMPARE_A_OUT} <= 2'b11;
		{I_TIMER3_COMPARE_B_EN, I_TIMER3_COMPARE_B_OUT} <= 2'b10;
		{I_TIMER3_COMPARE_C_EN, I_TIMER3_COMPARE_C_OUT} <= 2'b11;
		step(1);
		chk(O_PE_OUT[1], 8'h00);
		for (int k = 0; k < 2; k++) begin
			@(posedge I_REF_CLK);
			I_LEGACY_MODE <= k[0];
			step(1);
			chk(O_PE_OUT & 8'h3C, k ? 8'h00 : 8'h2C);
			chk(O_PE_OE & 8'h3C, 8'h3C);
			chk(O_PF_OE, k ? 8'h00 : 8'hFF);
		end
		@(posedge I_REF_CLK);
		I_LEGACY_MODE <= 0;
		I_TEST_PORT_ENABLE <= 1;
		I_GLOBAL_PULLUP_DISABLE <= 1;
		for (int i = 0; i < 16; i++) begin
			tck(tms_seq[i], tdi_seq[i]);
			if (i == 4) chk(O_TAP_STATE, 8'h00);
			if (i == 10) chk(O_PF_OUT & 8'h40, 8'h40);
			if (i == 9) begin
				chk(O_TAP_STATE, 8'h0B);
				chk(O_PF_OE & 8'hF0, 8'h40);
				chk(O_PF_PULLUP & 8'hF0, 8'hB0);
			end
		end
		chk({O_TAP_STATE, O_TAP_IR}, 8'h13);
		final_report;
	end
	initial begin
		repeat (5000) @(posedge I_REF_CLK);
		err_count++;
		final_report;
	end
endmodule // testbench
`default_nettype wire
